// [sar_adc_track_convert_sequencer_test.sv]
// Self-checking bench for the converter track/convert sequencer.
// Assumes satcs_pkg is compiled first; checks sit inside the design.
`timescale 1ns/100ps
module sar_adc_track_convert_sequencer_test;
  logic        ref_clk       = 1'b0;
  logic        rst           = 1'b1;
  logic [3:0]  addr          = 4'h0;
  logic [7:0]  wr_data       = 8'h00;
  logic        wr_en         = 1'b0;
  logic        rd_en         = 1'b0;
  logic [7:0]  rd_data_q;
  logic        conv_start_in = 1'b0;
  logic        burst_tick    = 1'b0;
  logic        burst_on      = 1'b0;
  logic [1:0]  bcnt          = 2'h0;
  logic        cmp_in;
  logic [11:0] target        = 12'hA5C;
  logic        sample_connect_q;
  logic        converting_q;
  logic [11:0] dac_code_q;
  logic [7:0]  gain_high_q;
  logic [3:0]  gain_low_q;
  logic        extra_gain_q;
  logic        conv_done_q;
  logic        irq_q;
  int          failures      = 0;
  int          checked       = 0;
  logic [7:0]  trk_tbl [3]   = '{8'h0D, 8'h03, 8'h3F};
  int          trk_exp [3]   = '{5, 2, 17};
  logic        cap_exp [3]   = '{1'b0, 1'b1, 1'b1};
  int          div_tbl [2]   = '{1, 31};

  satcs_seq u_dut
  (
    .ref_clk          (ref_clk),
    .rst              (rst),
    .addr             (addr),
    .wr_data          (wr_data),
    .wr_en            (wr_en),
    .rd_en            (rd_en),
    .rd_data_q        (rd_data_q),
    .conv_start_in    (conv_start_in),
    .burst_tick       (burst_tick),
    .cmp_in           (cmp_in),
    .sample_connect_q (sample_connect_q),
    .converting_q     (converting_q),
    .dac_code_q       (dac_code_q),
    .gain_high_q      (gain_high_q),
    .gain_low_q       (gain_low_q),
    .extra_gain_q     (extra_gain_q),
    .conv_done_q      (conv_done_q),
    .irq_q            (irq_q)
  );

  always #50 ref_clk = ~ref_clk;

  // Ideal comparator: keeps a trial bit while input is not below it
  assign cmp_in = (target >= dac_code_q);

  // Slow burst source, one tick in three cycles
  always @(posedge ref_clk)
  begin
    bcnt       <= (bcnt == 2'h2) ? 2'h0 : bcnt + 2'h1;
    burst_tick <= burst_on && (bcnt == 2'h2);
  end

  task automatic complete_run;
    $display("checked %0d, failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [11:0] e,
                     input logic [11:0] g);
    checked++;
    if (g !== e)
    begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    wr_en   <= 1'b1;
    addr    <= a;
    wr_data <= d;
    @(posedge ref_clk);
    wr_en   <= 1'b0;
    #1;
  endtask

  task automatic rdchk(input logic [3:0] a, input logic [7:0] e,
                       input string nm);
    @(posedge ref_clk);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1;
    chk(nm, {4'h0, e}, {4'h0, rd_data_q});
  endtask

  task automatic start_pulse;
    @(posedge ref_clk);
    conv_start_in <= 1'b1;
    @(posedge ref_clk);
    conv_start_in <= 1'b0;
  endtask

  // Counts tracking and converting cycles until the done pulse
  task automatic watch(input int bound, input bit must, output int trk,
                       output int cnv, output bit ok);
    int i;
    trk = 0;
    cnv = 0;
    ok  = 1'b0;
    for (i = 0; i < bound && !ok; i++)
    begin
      #1;
      if (conv_done_q === 1'b1)
        ok = 1'b1;
      else
      begin
        chk("track and convert", 12'h0, {11'h0, sample_connect_q & converting_q});
        if (sample_connect_q === 1'b1)
          trk++;
        if (converting_q === 1'b1)
          cnv++;
        @(posedge ref_clk);
      end
    end
    if (!ok && must)
    begin
      // A timeout is counted; later waits are bounded too
      failures++;
      $display("unexpected conv_done_q: expected 1, seen 0");
    end
  endtask

  task automatic run(output int trk, output int cnv);
    bit ok;
    start_pulse;
    watch(1000, 1'b1, trk, cnv, ok);
    @(posedge ref_clk);
    #1;
    chk("conv_done_q width", 12'h0, {11'h0, conv_done_q});
  endtask

  task automatic endtest(input string nm);
    $display("test %s finished", nm);
  endtask

  initial
  begin
    int  trk;
    int  cnv;
    bit  ok;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    chk("extra_gain_q", 12'h1, {11'h0, extra_gain_q});
    rdchk(satcs_pkg::ADDR_CFG, 8'hF8, "cfg");
    rdchk(satcs_pkg::ADDR_GAIN_HI, 8'h00, "gain hi");
    rdchk(satcs_pkg::ADDR_GAIN_LO, 8'h00, "gain lo");
    rdchk(satcs_pkg::ADDR_GAIN_ADD, 8'h01, "gain add");
    rdchk(satcs_pkg::ADDR_STAT, 8'h01, "stat idle");
    wr(4'hC, 8'hFF);
    rdchk(4'hC, 8'h00, "unmapped");
    endtest("reset");
    wr(satcs_pkg::ADDR_GAIN_HI, 8'hA5);
    chk("gain_high_q", 12'h0A5, {4'h0, gain_high_q});
    rdchk(satcs_pkg::ADDR_GAIN_HI, 8'hA5, "gain hi");
    wr(satcs_pkg::ADDR_GAIN_LO, 8'h50);
    chk("gain_low_q", 12'h005, {8'h0, gain_low_q});
    rdchk(satcs_pkg::ADDR_GAIN_LO, 8'h50, "gain lo");
    wr(satcs_pkg::ADDR_GAIN_ADD, 8'h00);
    chk("extra_gain_q", 12'h0, {11'h0, extra_gain_q});
    endtest("gain");
    // pre mode, system clock, no divide
    wr(satcs_pkg::ADDR_CFG, 8'h00);
    wr(satcs_pkg::ADDR_TRK, 8'h00);
    run(trk, cnv);
    chk("pre track cycles", 12'd0, 12'(trk));
    chk("pre conv cycles", 12'd15, 12'(cnv));
    chk("dac_code_q", 12'hA5C, dac_code_q);
    rdchk(satcs_pkg::ADDR_RES_HI, 8'hA5, "result hi");
    rdchk(satcs_pkg::ADDR_RES_LO, 8'hC0, "result lo");
    rdchk(satcs_pkg::ADDR_INT_STAT, 8'h01, "int stat");
    chk("irq_q masked", 12'h0, {11'h0, irq_q});
    wr(satcs_pkg::ADDR_INT_EN, 8'h01);
    rdchk(satcs_pkg::ADDR_INT_EN, 8'h01, "int en");
    chk("irq_q raised", 12'h1, {11'h0, irq_q});
    wr(satcs_pkg::ADDR_INT_CLR, 8'h01);
    rdchk(satcs_pkg::ADDR_INT_STAT, 8'h00, "int stat");
    rdchk(satcs_pkg::ADDR_INT_CLR, 8'h00, "int clr");
    chk("irq_q cleared", 12'h0, {11'h0, irq_q});
    endtest("pre");
    wr(satcs_pkg::ADDR_CTL, 8'h02);
    rdchk(satcs_pkg::ADDR_STAT, 8'h02, "stat sw track");
    run(trk, cnv);
    chk("sw track cycles", 12'd0, 12'(trk));
    chk("sw conv cycles", 12'd15, 12'(cnv));
    chk("sw track after conv", 12'h1, {11'h0, sample_connect_q});
    wr(satcs_pkg::ADDR_CTL, 8'h00);
    rdchk(satcs_pkg::ADDR_STAT, 8'h01, "stat sw idle");
    endtest("software track");
    foreach (div_tbl[j])
    begin
      wr(satcs_pkg::ADDR_CFG, 8'(div_tbl[j] << 3));
      run(trk, cnv);
      chk("div conv cycles", 12'(13 * (div_tbl[j] + 1) + 2), 12'(cnv));
    end
    endtest("divider");
    // start while converting is refused and flagged
    wr(satcs_pkg::ADDR_CFG, 8'h00);
    wr(satcs_pkg::ADDR_INT_CLR, 8'h03);
    start_pulse;
    repeat (3) @(posedge ref_clk);
    wr(satcs_pkg::ADDR_CTL, 8'h01);
    watch(100, 1'b1, trk, cnv, ok);
    rdchk(satcs_pkg::ADDR_INT_STAT, 8'h03, "int overrun");
    chk("irq_q", 12'h1, {11'h0, irq_q});
    wr(satcs_pkg::ADDR_INT_CLR, 8'h03);
    endtest("overrun");
    wr(satcs_pkg::ADDR_CFG, 8'h04);
    start_pulse;
    watch(60, 1'b0, trk, cnv, ok);
    #1;
    chk("done without burst", 12'h0, {11'h0, ok});
    chk("converting_q stalled", 12'h1, {11'h0, converting_q});
    @(posedge ref_clk);
    burst_on <= 1'b1;
    watch(1000, 1'b1, trk, cnv, ok);
    @(posedge ref_clk);
    burst_on <= 1'b0;
    endtest("burst");
    wr(satcs_pkg::ADDR_CFG, 8'h00);
    foreach (trk_tbl[k])
    begin
      // long track time leaves settling margin
      wr(satcs_pkg::ADDR_TRK, trk_tbl[k]);
      run(trk, cnv);
      chk("timed track cycles", 12'(trk_exp[k]), 12'(trk));
      chk("timed conv cycles", 12'd15, 12'(cnv));
      chk("cap after conv", {11'h0, cap_exp[k]}, {11'h0, sample_connect_q});
    end
    endtest("tracking");
    complete_run;
  end
endmodule

// [satcs_clkdiv.sv]
// Subsystem clock select and conversion clock divider.
// Assumes burst_tick is a one-cycle pulse synchronous to ref_clk.
`timescale 1ns/100ps
module satcs_clkdiv
(
  // Clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       rst,
  // Source select
  input  wire logic                       burst_sel,
  input  wire logic                       burst_tick,
  // Divider control
  input  wire logic [satcs_pkg::DIV_W-1:0] divider,
  input  wire logic                       restart,
  // Ticks
  output logic                            converter_subsystem_clock_tick,
  output logic                            sar_tick
);

  logic [satcs_pkg::DIV_W-1:0] div_cnt_q;

  assign converter_subsystem_clock_tick = burst_sel ? burst_tick : 1'b1;

  assign sar_tick = converter_subsystem_clock_tick && !restart && (div_cnt_q == divider);

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      div_cnt_q <= '0;
    else if (restart)
      div_cnt_q <= '0;
    else if (converter_subsystem_clock_tick)
      div_cnt_q <= (div_cnt_q == divider) ? '0 : div_cnt_q + 5'h01;
  end

endmodule

// [satcs_gain.sv]
// Selectable gain word registers.
// Assumes the register port decode of the sequencer top.
`timescale 1ns/100ps
module satcs_gain
(
  // Clock and reset
  input  wire logic                        ref_clk,
  input  wire logic                        rst,
  // Register write
  input  wire logic                        wr_en,
  input  wire logic [satcs_pkg::ADDR_W-1:0] addr,
  input  wire logic [satcs_pkg::DATA_W-1:0] wr_data,
  // Gain word
  output logic      [7:0]                  gain_high_q,
  output logic      [3:0]                  gain_low_q,
  output logic                             extra_gain_q
);

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      gain_high_q  <= satcs_pkg::GAIN_HI_RST;
      gain_low_q   <= satcs_pkg::GAIN_LO_RST;
      extra_gain_q <= satcs_pkg::GAIN_ADD_RST;
    end
    else if (wr_en)
    begin
      if (addr == satcs_pkg::ADDR_GAIN_HI)
        gain_high_q <= wr_data;
      if (addr == satcs_pkg::ADDR_GAIN_LO)
        gain_low_q <= wr_data[7:4];
      if (addr == satcs_pkg::ADDR_GAIN_ADD)
        extra_gain_q <= wr_data[0];
    end
  end

endmodule

// [satcs_pkg.sv]
// Constants for the converter track/convert sequencer.
// Assumes an 8-bit register port and one 10 MHz reference clock.
package satcs_pkg;

  // Register port
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  // Register offsets
  localparam logic [3:0] ADDR_CFG      = 4'h0;
  localparam logic [3:0] ADDR_TRK      = 4'h1;
  localparam logic [3:0] ADDR_CTL      = 4'h2;
  localparam logic [3:0] ADDR_STAT     = 4'h3;
  localparam logic [3:0] ADDR_GAIN_HI  = 4'h4;
  localparam logic [3:0] ADDR_RES_HI   = 4'h5;
  localparam logic [3:0] ADDR_RES_LO   = 4'h6;
  localparam logic [3:0] ADDR_GAIN_LO  = 4'h7;
  localparam logic [3:0] ADDR_GAIN_ADD = 4'h8;
  localparam logic [3:0] ADDR_INT_STAT = 4'h9;
  localparam logic [3:0] ADDR_INT_CLR  = 4'hA;
  localparam logic [3:0] ADDR_INT_EN   = 4'hB;

  // Configuration register fields
  localparam int DIV_LSB   = 3;
  localparam int DIV_W     = 5;
  localparam int BURST_BIT = 2;
  localparam logic [7:0] CFG_RST = 8'hF8;

  // Tracking register fields
  localparam int MODE_LSB = 0;
  localparam int TK_LSB   = 2;
  localparam int TK_W     = 4;
  localparam logic [7:0] TRK_RST = 8'h00;

  // Control register bits
  localparam int CTL_START_BIT = 0;
  localparam int CTL_SWTRK_BIT = 1;

  // Tracking modes
  localparam logic [1:0] MODE_PRE  = 2'h0;
  localparam logic [1:0] MODE_POST = 2'h1;
  localparam logic [1:0] MODE_DUAL = 2'h3;

  // Conversion timing
  localparam logic [3:0] SAR_CYCLES  = 4'hD;
  localparam logic [3:0] SAR_LAST    = 4'hC;
  localparam logic [4:0] TRACK_EXTRA = 5'h02;

  // Interrupt bits
  localparam int INT_DONE = 0;
  localparam int INT_OVR  = 1;
  localparam int INT_W    = 2;

  // Gain register reset values
  localparam logic [7:0] GAIN_HI_RST  = 8'h00;
  localparam logic [3:0] GAIN_LO_RST  = 4'h0;
  localparam logic       GAIN_ADD_RST = 1'b1;

  typedef enum logic [2:0]
  {
    ST_IDLE  = 3'b001,
    ST_TRACK = 3'b010,
    ST_CONV  = 3'b100
  } satcs_state_e;

endpackage

// [satcs_seq.sv]
// Track/convert sequencer of a 12-bit successive-approximation converter.
// Assumes synchronous inputs and an 8-bit strobe register port.
//
// Summary of operation
// - Post mode: timed tracking, then convert
// - Post mode: input disconnected after conversion
// - Dual mode: timed track, convert, track on
// - Subsystem clock from system or burst
// - Conversion clock is divided subsystem clock
// - Exactly one of idle, track, convert
// - Pre mode: convert at once on start
// - Timed tracking lasts field plus two ticks
// - Conversion is 13 SAR plus 2 ticks
// - Gain high byte holds eight bits
`timescale 1ns/100ps
module satcs_seq
(
  // Clock and reset
  input  wire logic                        ref_clk,
  input  wire logic                        rst,
  // Register port
  input  wire logic [satcs_pkg::ADDR_W-1:0] addr,
  input  wire logic [satcs_pkg::DATA_W-1:0] wr_data,
  input  wire logic                        wr_en,
  input  wire logic                        rd_en,
  output logic      [satcs_pkg::DATA_W-1:0] rd_data_q,
  // Start and clock sources
  input  wire logic                        conv_start_in,
  input  wire logic                        burst_tick,
  // Analog front end
  input  wire logic                        cmp_in,
  output logic                             sample_connect_q,
  output logic                             converting_q,
  output logic      [11:0]                 dac_code_q,
  output logic      [7:0]                  gain_high_q,
  output logic      [3:0]                  gain_low_q,
  output logic                             extra_gain_q,
  // Events
  output logic                             conv_done_q,
  output logic                             irq_q
);

  satcs_pkg::satcs_state_e state_q;
  satcs_pkg::satcs_state_e state_d;

  logic [7:0]                    cfg_q;
  logic [7:0]                    trk_q;
  logic                          swtrk_q;
  logic [satcs_pkg::INT_W-1:0]   int_stat_q;
  logic [satcs_pkg::INT_W-1:0]   int_en_q;
  logic [11:0]                   result_q;
  logic                          timed_q;
  logic [4:0]                    trk_cnt_q;
  logic [1:0]                    cph_q;
  logic [3:0]                    sar_cnt_q;
  logic                          converter_subsystem_clock_tick;
  logic                          sar_tick;
  logic                          start;
  logic                          track_end;
  logic                          conv_end;
  logic                          overrun;
  logic [1:0]                    mode;
  logic [4:0]                    tk;

  function automatic logic [11:0] bit_mask(input logic [3:0] idx);
    bit_mask = 12'h001 << idx;
  endfunction

  assign mode = trk_q[satcs_pkg::MODE_LSB +: 2];
  assign tk   = {1'b0, trk_q[satcs_pkg::TK_LSB +: satcs_pkg::TK_W]};
  assign start = conv_start_in ||
                 (wr_en && addr == satcs_pkg::ADDR_CTL &&
                  wr_data[satcs_pkg::CTL_START_BIT]);
  // Starts during a conversion or a timed track are dropped and flagged
  assign overrun = start && (state_q == satcs_pkg::ST_CONV ||
                             (state_q == satcs_pkg::ST_TRACK && timed_q));
  assign track_end = state_q == satcs_pkg::ST_TRACK && timed_q &&
                     converter_subsystem_clock_tick && trk_cnt_q == tk + 5'h01;
  assign conv_end = state_q == satcs_pkg::ST_CONV && cph_q == 2'h2 &&
                    converter_subsystem_clock_tick;

  satcs_clkdiv u_clkdiv
  (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .burst_sel  (cfg_q[satcs_pkg::BURST_BIT]),
    .burst_tick (burst_tick),
    .divider    (cfg_q[satcs_pkg::DIV_LSB +: satcs_pkg::DIV_W]),
    .restart    (!(state_q == satcs_pkg::ST_CONV && cph_q == 2'h1)),
    .converter_subsystem_clock_tick  (converter_subsystem_clock_tick),
    .sar_tick   (sar_tick)
  );

  satcs_gain u_gain
  (
    .ref_clk      (ref_clk),
    .rst          (rst),
    .wr_en        (wr_en),
    .addr         (addr),
    .wr_data      (wr_data),
    .gain_high_q  (gain_high_q),
    .gain_low_q   (gain_low_q),
    .extra_gain_q (extra_gain_q)
  );

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      satcs_pkg::ST_IDLE:
      begin
        if (start && mode != satcs_pkg::MODE_POST &&
            mode != satcs_pkg::MODE_DUAL)
          state_d = satcs_pkg::ST_CONV;
        else if (start)
          state_d = satcs_pkg::ST_TRACK;
        else if (swtrk_q && mode == satcs_pkg::MODE_PRE)
          state_d = satcs_pkg::ST_TRACK;
      end
      satcs_pkg::ST_TRACK:
      begin
        if (track_end)
          state_d = satcs_pkg::ST_CONV;
        else if (!timed_q && start && mode != satcs_pkg::MODE_POST &&
                 mode != satcs_pkg::MODE_DUAL)
          state_d = satcs_pkg::ST_CONV;
        else if (!timed_q && !start && mode == satcs_pkg::MODE_PRE &&
                 !swtrk_q)
          state_d = satcs_pkg::ST_IDLE;
      end
      satcs_pkg::ST_CONV:
      begin
        if (conv_end && mode == satcs_pkg::MODE_DUAL)
          state_d = satcs_pkg::ST_TRACK;
        else if (conv_end && mode == satcs_pkg::MODE_PRE && swtrk_q)
          state_d = satcs_pkg::ST_TRACK;
        else if (conv_end)
          state_d = satcs_pkg::ST_IDLE;
      end
      default:
        state_d = satcs_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state_q          <= satcs_pkg::ST_IDLE;
      sample_connect_q <= 1'b0;
      converting_q     <= 1'b0;
    end
    else
    begin
      state_q          <= state_d;
      sample_connect_q <= state_d == satcs_pkg::ST_TRACK;
      converting_q     <= state_d == satcs_pkg::ST_CONV;
    end
  end

  // Tracking interval counter
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      timed_q   <= 1'b0;
      trk_cnt_q <= '0;
    end
    else if (state_d == satcs_pkg::ST_TRACK && start && !overrun)
    begin
      timed_q   <= 1'b1;
      trk_cnt_q <= '0;
    end
    else if (state_d != satcs_pkg::ST_TRACK)
    begin
      timed_q   <= 1'b0;
      trk_cnt_q <= '0;
    end
    else if (timed_q && converter_subsystem_clock_tick)
      trk_cnt_q <= trk_cnt_q + 5'h01;
  end

  // start tick, 13 SAR ticks, end tick
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      cph_q      <= 2'h0;
      sar_cnt_q  <= 4'h0;
      dac_code_q <= 12'h000;
      result_q   <= 12'h000;
    end
    else if (state_q != satcs_pkg::ST_CONV)
    begin
      cph_q     <= 2'h0;
      sar_cnt_q <= 4'h0;
    end
    else if (cph_q == 2'h0 && converter_subsystem_clock_tick)
    begin
      cph_q      <= 2'h1;
      dac_code_q <= 12'h800;
    end
    else if (cph_q == 2'h1 && sar_tick)
    begin
      sar_cnt_q <= sar_cnt_q + 4'h1;
      if (sar_cnt_q == satcs_pkg::SAR_LAST)
      begin
        cph_q    <= 2'h2;
        result_q <= dac_code_q;
      end
      else
      begin
        dac_code_q <= (cmp_in ? dac_code_q :
                       dac_code_q & ~bit_mask(4'hB - sar_cnt_q)) |
                      ((sar_cnt_q == 4'hB) ? 12'h000 :
                       bit_mask(4'hA - sar_cnt_q));
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      conv_done_q <= 1'b0;
    else
      conv_done_q <= conv_end;
  end

  // Configuration and enables
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      cfg_q    <= satcs_pkg::CFG_RST;
      trk_q    <= satcs_pkg::TRK_RST;
      swtrk_q  <= 1'b0;
      int_en_q <= '0;
    end
    else if (wr_en)
    begin
      if (addr == satcs_pkg::ADDR_CFG)
        cfg_q <= wr_data;
      if (addr == satcs_pkg::ADDR_TRK)
        trk_q <= wr_data;
      if (addr == satcs_pkg::ADDR_CTL)
        swtrk_q <= wr_data[satcs_pkg::CTL_SWTRK_BIT];
      if (addr == satcs_pkg::ADDR_INT_EN)
        int_en_q <= wr_data[satcs_pkg::INT_W-1:0];
    end
  end

  // Sticky events; a set beats a clear in the same cycle
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      int_stat_q <= '0;
    else
    begin
      for (int i = 0; i < satcs_pkg::INT_W; i++)
      begin
        if ((i == satcs_pkg::INT_DONE && conv_end) ||
            (i == satcs_pkg::INT_OVR && overrun))
          int_stat_q[i] <= 1'b1;
        else if (wr_en && addr == satcs_pkg::ADDR_INT_CLR && wr_data[i])
          int_stat_q[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      irq_q <= 1'b0;
    else
      irq_q <= |(int_stat_q & int_en_q);
  end

  // Read data stands one cycle after the strobe
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      rd_data_q <= 8'h00;
    else if (!rd_en)
      rd_data_q <= 8'h00;
    else
    begin
      unique case (addr)
        satcs_pkg::ADDR_CFG:      rd_data_q <= cfg_q;
        satcs_pkg::ADDR_TRK:      rd_data_q <= trk_q;
        satcs_pkg::ADDR_CTL:      rd_data_q <= {6'h00, swtrk_q, 1'b0};
        satcs_pkg::ADDR_STAT:     rd_data_q <= {4'h0, timed_q, state_q};
        satcs_pkg::ADDR_GAIN_HI:  rd_data_q <= gain_high_q;
        satcs_pkg::ADDR_RES_HI:   rd_data_q <= result_q[11:4];
        satcs_pkg::ADDR_RES_LO:   rd_data_q <= {result_q[3:0], 4'h0};
        // Reserved nibble reads zero
        satcs_pkg::ADDR_GAIN_LO:  rd_data_q <= {gain_low_q, 4'h0};
        satcs_pkg::ADDR_GAIN_ADD: rd_data_q <= {7'h00, extra_gain_q};
        satcs_pkg::ADDR_INT_STAT: rd_data_q <= {6'h00, int_stat_q};
        satcs_pkg::ADDR_INT_EN:   rd_data_q <= {6'h00, int_en_q};
        default:                  rd_data_q <= 8'h00;
      endcase
    end
  end

  // Checking helpers
  logic [4:0] hlp_trk_q;
  logic [3:0] hlp_sar_q;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      hlp_trk_q <= '0;
      hlp_sar_q <= '0;
    end
    else
    begin
      if (state_q == satcs_pkg::ST_TRACK && timed_q)
        hlp_trk_q <= hlp_trk_q + {4'h0, converter_subsystem_clock_tick};
      else
        hlp_trk_q <= '0;
      if (state_q == satcs_pkg::ST_CONV)
        hlp_sar_q <= hlp_sar_q + {3'h0, sar_tick};
      else
        hlp_sar_q <= '0;
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  chk_one_state:
    assert property ($onehot(state_q))
    else $error("sequencer state not one-hot");
  chk_post_track:
    assert property (start && state_q == satcs_pkg::ST_IDLE &&
                     mode == satcs_pkg::MODE_POST |=>
                     state_q == satcs_pkg::ST_TRACK && timed_q)
    else $error("post start did not begin timed tracking");
  chk_track_len:
    assert property (state_q == satcs_pkg::ST_CONV &&
                     $past(state_q == satcs_pkg::ST_TRACK && timed_q) |->
                     hlp_trk_q == tk + satcs_pkg::TRACK_EXTRA)
    else $error("tracking interval length wrong");
  chk_sar_count:
    assert property (conv_done_q |-> hlp_sar_q == satcs_pkg::SAR_CYCLES)
    else $error("conversion did not last 13 SAR ticks");
  chk_post_open:
    assert property (conv_done_q && mode == satcs_pkg::MODE_POST |->
                     !sample_connect_q && state_q == satcs_pkg::ST_IDLE)
    else $error("post mode still sampling after conversion");
  chk_dual_track:
    assert property (conv_done_q && mode == satcs_pkg::MODE_DUAL |->
                     sample_connect_q)
    else $error("dual mode not tracking after conversion");
  chk_pre_conv:
    assert property (start && mode == satcs_pkg::MODE_PRE &&
                     state_q != satcs_pkg::ST_CONV |=> converting_q)
    else $error("pre mode start did not convert at once");
  chk_sys_clk:
    assert property (!cfg_q[satcs_pkg::BURST_BIT] |-> converter_subsystem_clock_tick)
    else $error("subsystem tick missing on system clock");
  chk_sar_div:
    assert property (sar_tick |-> converter_subsystem_clock_tick)
    else $error("SAR tick without subsystem tick");
  chk_done_flag:
    assert property (conv_done_q |-> int_stat_q[satcs_pkg::INT_DONE])
    else $error("done flag not set after conversion");
  chk_gain_high:
    assert property (wr_en && addr == satcs_pkg::ADDR_GAIN_HI |=>
                     gain_high_q == $past(wr_data))
    else $error("gain high byte not stored");

  cov_post: cover property (conv_done_q && mode == satcs_pkg::MODE_POST);
  cov_dual: cover property (conv_done_q && mode == satcs_pkg::MODE_DUAL);
  cov_pre:  cover property (conv_done_q && mode == satcs_pkg::MODE_PRE);
  cov_ovr:  cover property (overrun);

endmodule
